// *** rtl/puw_regs.svh ***
// Register offsets, field positions, reset values and timing figures of the
// upstream window and preemption register bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PUW_REGS_SVH
`define PUW_REGS_SVH

// Byte offsets of the registers on the register bus.
`define PUW_OFF_UP_CTRL      8'h48
`define PUW_OFF_PREEMPT      8'h4C
`define PUW_OFF_WINDOW       8'h50
`define PUW_OFF_BASE_HIGH    8'h54
`define PUW_OFF_LIMIT_HIGH   8'h58

// Field positions.
`define PUW_PRE_HI           31
`define PUW_PRE_LO           28
`define PUW_PRE_OFF_BIT      31
`define PUW_ENA_BIT          16
`define PUW_BASE_HI          15
`define PUW_BASE_LO          4
`define PUW_BCAP_HI          3
`define PUW_BCAP_LO          0
`define PUW_LCAP_HI          19
`define PUW_LCAP_LO          16
`define PUW_LIMIT_HI         31
`define PUW_LIMIT_LO         20

// Reset and fixed values.
`define PUW_RST_PREEMPT      4'h0
`define PUW_RST_ENA          1'h0
`define PUW_RST_BASE         12'h000
`define PUW_RST_LIMIT        12'h000
`define PUW_RST_HIGH         32'h0000_0000
`define PUW_CAP_64BIT        4'h1

// Fill of the address bits below the 1 MB granule of base and limit.
`define PUW_GRAN_ZERO        20'h0_0000
`define PUW_GRAN_ONES        20'hF_FFFF

// Longest preemption delay in clock cycles.
`define PUW_MAX_DELAY        64

`endif

// *** rtl/puw_pkg.sv ***
// Types shared by the upstream window and preemption register bank.
// Assumes the register header is on the include path.
`include "puw_regs.svh"

package puw_pkg;

  // Four-bit preemption code as software writes it.
  typedef logic [3:0] puw_code_type;

  // Register selected by a bus address.
  typedef enum logic [2:0] {
    PUW_SEL_NONE,
    PUW_SEL_CTRL,
    PUW_SEL_PREEMPT,
    PUW_SEL_WINDOW,
    PUW_SEL_BASE_HIGH,
    PUW_SEL_LIMIT_HIGH
  } puw_sel_type;

endpackage

// *** rtl/puw_preempt_timer.sv ***
// Preemption timer: counts clocks from secondary FRAME assertion and
// tells the arbiter when the current owner may be preempted.
// Assumes frame_n comes straight from the pin and the code from a register.
`timescale 1ns/1ps
`include "puw_regs.svh"

module puw_preempt_timer #(
  parameter int CNT_W = 7                 // Counter width, must hold the longest delay.
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  frame_n,
  input  wire puw_pkg::puw_code_type code,
  output logic                       preempt_allow
);
  import puw_pkg::*;

  logic             frame_meta_reg;       // First synchroniser stage.
  logic             frame_sync_reg;       // Second stage, active low FRAME.
  logic             frame_act;            // FRAME seen asserted.
  logic [CNT_W-1:0] cnt_reg;              // Cycles since FRAME asserted.
  logic [CNT_W-1:0] delay;                // Cycles the code asks for.

  // Refuse a counter too narrow to reach the longest delay.
  if ((1 << CNT_W) <= `PUW_MAX_DELAY) begin : g_chk
    $error("CNT_W too small for the longest preemption delay.");
  end

  // Delay of a code: 0, 1, then doubling from 2 up to the longest.
  function automatic logic [CNT_W-1:0] delay_of(input puw_code_type c);
    logic [CNT_W-1:0] d;
    d = '0;
    if (c[2:0] != 3'h0) begin
      d = CNT_W'(1) << (c[2:0] - 3'h1);
    end
    return d;
  endfunction

  // FRAME is a pin, so it passes two flops before anything reads it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_meta_reg <= 1'b1;
      frame_sync_reg <= 1'b1;
    end else begin
      frame_meta_reg <= frame_n;
      frame_sync_reg <= frame_meta_reg;
    end
  end

  assign frame_act = ~frame_sync_reg;
  assign delay     = delay_of(code);

  // Count from the first cycle FRAME is seen; saturate so long bursts hold.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
    end else if (!frame_act) begin
      cnt_reg <= '0;
    end else if (cnt_reg != {CNT_W{1'b1}}) begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // Code 0 allows at once, others after their delay; top bit set never allows.
  assign preempt_allow = frame_act && !code[3] && (cnt_reg >= delay);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // A fresh FRAME with code 1 in force.
  sequence frame_start_c1;
    $rose(frame_act) && code == 4'h1;
  endsequence

  preempt_off_a: assert property (code[3] |-> !preempt_allow)
    else $error("Preemption allowed although it is switched off.");
  immediate_allow_a: assert property ($rose(frame_act) && code == 4'h0 |-> preempt_allow)
    else $error("Code 0 did not allow preemption at FRAME.");
  one_cycle_a: assert property (frame_start_c1 |-> !preempt_allow ##1
                                (preempt_allow || !frame_act || code != 4'h1))
    else $error("Code 1 did not allow preemption one cycle after FRAME.");
  delay_table_a: assert property ($rose(frame_act) && code == 4'h4
                                  ##1 (frame_act && code == 4'h4) [*7]
                                  |-> !preempt_allow ##1 (preempt_allow || !frame_act))
    else $error("Code 4 did not wait exactly eight cycles.");
  delay_floor_a: assert property (preempt_allow |-> cnt_reg >= delay && frame_act)
    else $error("Preemption allowed before its delay ran out.");

endmodule

// *** rtl/puw_window_regs.sv ***
// Upstream window and secondary arbiter preemption registers behind an
// AHB-Lite slave, with the preemption timer and the upstream window check.
// Assumes one AHB-Lite master, word transfers, and FRAME from the secondary pin.
`timescale 1ns/1ps
`include "puw_regs.svh"

module puw_window_regs #(
  parameter int CNT_W = 7                    // Width of the preemption counter.
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        frame_n,
  output logic             preempt_allow,
  input  wire logic        sec_mem_req,
  input  wire logic [63:0] sec_mem_addr,
  input  wire logic        down_window_hit,
  output logic             up_fwd_valid,
  output logic             up_fwd
);
  import puw_pkg::*;

  // Software state.
  puw_code_type preempt_reg;                 // Preemption code.
  puw_code_type preempt_next;
  logic         ena_reg;                     // Window confinement enable.
  logic         ena_next;
  logic [11:0]  base_reg;                    // Base address bits 31:20.
  logic [11:0]  base_next;
  logic [11:0]  limit_reg;                   // Limit address bits 31:20.
  logic [11:0]  limit_next;
  logic [31:0]  base_high_reg;               // Base address bits 63:32.
  logic [31:0]  base_high_next;
  logic [31:0]  limit_high_reg;              // Limit address bits 63:32.
  logic [31:0]  limit_high_next;

  // Bus pipeline state.
  logic         addr_take;                   // An address phase is accepted.
  logic         wr_phase_reg;                // A write data phase is in progress.
  logic         wr_ok_reg;                   // That write is a whole word.
  puw_sel_type  wsel_reg;                    // Register written in the data phase.
  puw_sel_type  rsel;                        // Register read in the address phase.
  logic [31:0]  rdata_reg;                   // Read data for the next data phase.
  logic [31:0]  rdata_next;

  // Window check.
  logic [63:0]  win_lo;                      // Lowest address in the window.
  logic [63:0]  win_hi;                      // Highest address in the window.
  logic         in_window;                   // Address falls inside the window.
  logic         fwd_reg;                     // Forwarding decision.
  logic         fwd_valid_reg;               // Decision is fresh this cycle.

  // Map a byte address onto a register; other offsets select nothing.
  function automatic puw_sel_type sel_of(input logic [31:0] a);
    puw_sel_type s;
    s = PUW_SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[7:0])
        `PUW_OFF_UP_CTRL:    s = PUW_SEL_CTRL;
        `PUW_OFF_PREEMPT:    s = PUW_SEL_PREEMPT;
        `PUW_OFF_WINDOW:     s = PUW_SEL_WINDOW;
        `PUW_OFF_BASE_HIGH:  s = PUW_SEL_BASE_HIGH;
        `PUW_OFF_LIMIT_HIGH: s = PUW_SEL_LIMIT_HIGH;
        default:             s = PUW_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // The slave never stretches a transfer and never reports an error.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  // An address phase counts only when the bus is ready and the transfer is NONSEQ or SEQ.
  assign addr_take = hsel && hready && htrans[1];
  assign rsel      = sel_of(haddr);

  // Remember a write address phase so that its data can land next cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_phase_reg <= 1'b0;
      wr_ok_reg    <= 1'b0;
      wsel_reg     <= PUW_SEL_NONE;
    end else if (hready) begin
      wr_phase_reg <= addr_take && hwrite;
      wr_ok_reg    <= hsize == 3'h2;
      wsel_reg     <= sel_of(haddr);
    end
  end

  // Next values of every writable field; read-only nibbles have no storage,
  // so a write simply cannot reach them.
  always_comb begin
    preempt_next    = preempt_reg;
    ena_next        = ena_reg;
    base_next       = base_reg;
    limit_next      = limit_reg;
    base_high_next  = base_high_reg;
    limit_high_next = limit_high_reg;
    if (wr_phase_reg && wr_ok_reg) begin
      case (wsel_reg)
        PUW_SEL_CTRL: begin
          ena_next = hwdata[`PUW_ENA_BIT];
        end
        PUW_SEL_PREEMPT: begin
          preempt_next = hwdata[`PUW_PRE_HI:`PUW_PRE_LO];
        end
        PUW_SEL_WINDOW: begin
          base_next  = hwdata[`PUW_BASE_HI:`PUW_BASE_LO];
          limit_next = hwdata[`PUW_LIMIT_HI:`PUW_LIMIT_LO];
        end
        PUW_SEL_BASE_HIGH: begin
          base_high_next = hwdata;
        end
        PUW_SEL_LIMIT_HIGH: begin
          limit_high_next = hwdata;
        end
        default: begin
          preempt_next = preempt_reg;
        end
      endcase
    end
  end

  // Preemption code register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      preempt_reg <= `PUW_RST_PREEMPT;
    end else begin
      preempt_reg <= preempt_next;
    end
  end

  // Window confinement enable.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ena_reg <= `PUW_RST_ENA;
    end else begin
      ena_reg <= ena_next;
    end
  end

  // Base and limit granule fields, both in the word at the window offset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_reg  <= `PUW_RST_BASE;
      limit_reg <= `PUW_RST_LIMIT;
    end else begin
      base_reg  <= base_next;
      limit_reg <= limit_next;
    end
  end

  // Upper address words of base and limit.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_high_reg  <= `PUW_RST_HIGH;
      limit_high_reg <= `PUW_RST_HIGH;
    end else begin
      base_high_reg  <= base_high_next;
      limit_high_reg <= limit_high_next;
    end
  end

  // Read data is built from the next values, so a read right behind a write
  // to the same register already sees the new contents without a wait state.
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (rsel)
      PUW_SEL_CTRL: begin
        rdata_next[`PUW_ENA_BIT] = ena_next;
      end
      PUW_SEL_PREEMPT: begin
        rdata_next[`PUW_PRE_HI:`PUW_PRE_LO] = preempt_next;
      end
      PUW_SEL_WINDOW: begin
        rdata_next[`PUW_BCAP_HI:`PUW_BCAP_LO]   = `PUW_CAP_64BIT;
        rdata_next[`PUW_BASE_HI:`PUW_BASE_LO]   = base_next;
        rdata_next[`PUW_LCAP_HI:`PUW_LCAP_LO]   = `PUW_CAP_64BIT;
        rdata_next[`PUW_LIMIT_HI:`PUW_LIMIT_LO] = limit_next;
      end
      PUW_SEL_BASE_HIGH: begin
        rdata_next = base_high_next;
      end
      PUW_SEL_LIMIT_HIGH: begin
        rdata_next = limit_high_next;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // Capture read data at the end of a read address phase; it then stands
  // through the data phase and until the next read is taken.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      rdata_reg <= rdata_next;
    end
  end

  // Preemption timing lives in its own module next to the FRAME synchroniser.
  puw_preempt_timer #(
    .CNT_W         (CNT_W)
  ) u_timer (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .frame_n       (frame_n),
    .code          (preempt_reg),
    .preempt_allow (preempt_allow)
  );

  // Window bounds: base starts on a 1 MB granule, limit ends on one.
  assign win_lo    = {base_high_reg, base_reg, `PUW_GRAN_ZERO};
  assign win_hi    = {limit_high_reg, limit_reg, `PUW_GRAN_ONES};
  assign in_window = (sec_mem_addr >= win_lo) && (sec_mem_addr <= win_hi);

  // Decide upstream forwarding one cycle after each request. With the enable
  // low the window registers are ignored and only the downstream hit counts.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fwd_reg       <= 1'b0;
      fwd_valid_reg <= 1'b0;
    end else begin
      fwd_valid_reg <= sec_mem_req;
      if (sec_mem_req) begin
        if (ena_reg) begin
          fwd_reg <= in_window;
        end else begin
          fwd_reg <= !down_window_hit;
        end
      end
    end
  end

  assign up_fwd_valid = fwd_valid_reg;
  assign up_fwd       = fwd_reg;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // A whole-word write address phase to a given offset.
  sequence word_write(logic [7:0] off);
    addr_take && hwrite && hsize == 3'h2 && haddr[7:0] == off;
  endsequence

  // A read address phase to the window word.
  sequence window_read;
    addr_take && !hwrite && haddr[7:0] == `PUW_OFF_WINDOW;
  endsequence

  base_cap_ro_a: assert property (window_read |=> hrdata[3:0] == 4'h1)
    else $error("Base capability nibble did not read as one.");
  limit_cap_ro_a: assert property (window_read |=> hrdata[19:16] == 4'h1)
    else $error("Limit capability nibble did not read as one.");
  base_write_a: assert property (word_write(`PUW_OFF_WINDOW) ##1 1'b1
                                 |=> base_reg == $past(hwdata[15:4]))
    else $error("Base field did not take the written value.");
  limit_write_a: assert property (word_write(`PUW_OFF_WINDOW) ##1 1'b1
                                  |=> limit_reg == $past(hwdata[31:20]))
    else $error("Limit field did not take the written value.");
  base_high_a: assert property (word_write(`PUW_OFF_BASE_HIGH) ##1 1'b1
                                |=> base_high_reg == $past(hwdata))
    else $error("Base high word did not take the written value.");
  limit_high_a: assert property (word_write(`PUW_OFF_LIMIT_HIGH) ##1 1'b1
                                 |=> limit_high_reg == $past(hwdata))
    else $error("Limit high word did not take the written value.");
  preempt_write_a: assert property (word_write(`PUW_OFF_PREEMPT) ##1 1'b1
                                    |=> preempt_reg == $past(hwdata[31:28]))
    else $error("Preemption code did not take the written value.");
  open_window_a: assert property (sec_mem_req && !ena_reg
                                  |=> up_fwd_valid && up_fwd == !$past(down_window_hit))
    else $error("Open window forwarding disagrees with the downstream hit.");
  below_base_a: assert property (sec_mem_req && ena_reg && sec_mem_addr < win_lo
                                 |=> up_fwd_valid && !up_fwd)
    else $error("Address below the base was forwarded upstream.");
  at_limit_a: assert property (sec_mem_req && ena_reg && sec_mem_addr == win_hi
                               && win_lo <= win_hi |=> up_fwd)
    else $error("Address at the limit was not forwarded upstream.");

endmodule

// *** verification/puw_window_regs_tb_top.sv ***
// Self-checking testbench of the upstream window and preemption register bank.
// Assumes the design package and header are compiled first and one AHB-Lite master.
`timescale 1ns/1ps

module puw_window_regs_tb_top;
  import puw_pkg::*;

  // One register test: write a word, then read it back.
  typedef struct {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
  } puw_row_type;

  localparam int CLK_HALF = 25;        // Half period of the 20 MHz clock in ns.
  localparam int WATCHDOG_NS = 1000000; // Far beyond the few hundred cycles needed.

  logic        hclk;                   // Bus clock.
  logic        hresetn;                // Asynchronous reset, active low.
  logic        hsel;                   // Slave select.
  logic [31:0] haddr;                  // Byte address.
  logic [1:0]  htrans;                 // Transfer type.
  logic        hwrite;                 // Write strobe.
  logic [2:0]  hsize;                  // Transfer size.
  logic [31:0] hwdata;                 // Write data.
  logic        hready;                 // Bus ready, the slave's own ready.
  logic        hreadyout;              // Slave ready.
  logic        hresp;                  // Slave response.
  logic [31:0] hrdata;                 // Read data.
  logic        frame_n;                // Secondary frame pin, active low.
  logic        preempt_allow;          // Arbiter may preempt.
  logic        sec_mem_req;            // Secondary memory request pulse.
  logic [63:0] sec_mem_addr;           // Its address.
  logic        down_window_hit;        // Address hits the downstream window.
  logic        up_fwd_valid;           // Decision strobe.
  logic        up_fwd;                 // Forward upstream decision.
  int          fails;                  // Mismatches seen.
  int          num_checks;             // Comparisons made.
  logic [31:0] rd;                     // Last word read.

  // Ordinary register cases: written value and what must read back.
  puw_row_type rows [8] = '{
    '{8'h4C, 32'hFFFF_FFFF, 32'hF000_0000},
    '{8'h4C, 32'h5A5A_5A5A, 32'h5000_0000},
    '{8'h50, 32'hFFFF_FFFF, 32'hFFF1_FFF1},
    '{8'h50, 32'h0000_0000, 32'h0001_0001},
    '{8'h54, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
    '{8'h58, 32'h1234_5678, 32'h1234_5678},
    '{8'h48, 32'hFFFF_FFFF, 32'h0001_0000},
    '{8'h60, 32'hFFFF_FFFF, 32'h0000_0000}
  };

  // With a single slave the bus ready is the slave's own ready.
  assign hready = hreadyout;

  puw_window_regs #(
    .CNT_W (7)
  ) puw_window_regs_i (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .hsel            (hsel),
    .haddr           (haddr),
    .htrans          (htrans),
    .hwrite          (hwrite),
    .hsize           (hsize),
    .hwdata          (hwdata),
    .hready          (hready),
    .hreadyout       (hreadyout),
    .hresp           (hresp),
    .hrdata          (hrdata),
    .frame_n         (frame_n),
    .preempt_allow   (preempt_allow),
    .sec_mem_req     (sec_mem_req),
    .sec_mem_addr    (sec_mem_addr),
    .down_window_hit (down_window_hit),
    .up_fwd_valid    (up_fwd_valid),
    .up_fwd          (up_fwd)
  );

  // Free-running bus clock.
  initial begin
    hclk = 1'b0;
    forever #(CLK_HALF) hclk = ~hclk;
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (act !== exp) begin
      fails = fails + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("Checks: %0d, mismatches: %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Single word write: address phase held until ready, then the data phase.
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr  <= {24'h00_0000, a};
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask

  // Single word read; the data is taken at the edge that ends the data phase.
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    haddr  <= {24'h00_0000, a};
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    d = hrdata;
    // The slave must answer every transfer with an OKAY response.
    chk(32'(hresp), 32'h0);
  endtask

  // Frames the secondary bus and counts edges until preemption is allowed.
  // The count starts after the edge that drives the pin, so it holds the two
  // synchroniser edges and then the delay of the code itself.
  task automatic preempt_case(input logic [3:0] code);
    int n;
    int exp_n;
    bus_write(8'h4C, {code, 28'h000_0000});
    exp_n = (code == 4'h0) ? 2 : 2 + (1 << (code - 1));
    @(posedge hclk);
    frame_n <= 1'b0;
    n = 0;
    while (n < 90) begin
      @(posedge hclk);
      n = n + 1;
      #1;
      if (preempt_allow === 1'b1) break;
    end
    if (code[3]) chk(32'(preempt_allow), 32'h0);
    else chk(32'(n), 32'(exp_n));
    @(posedge hclk);
    frame_n <= 1'b1;
    repeat (4) @(posedge hclk);
    #1;
    chk(32'(preempt_allow), 32'h0);
  endtask

  // Presents one secondary memory request and checks the decision a cycle on.
  task automatic win_case(input logic [63:0] a, input logic hit, input logic exp);
    @(posedge hclk);
    sec_mem_req     <= 1'b1;
    sec_mem_addr    <= a;
    down_window_hit <= hit;
    @(posedge hclk);
    sec_mem_req <= 1'b0;
    #1;
    chk(32'(up_fwd_valid), 32'h1);
    chk(32'(up_fwd), 32'(exp));
  endtask

  // Main sequence.
  initial begin
    fails           = 0;
    num_checks      = 0;
    hresetn         = 1'b0;
    hsel            = 1'b0;
    haddr           = 32'h0000_0000;
    htrans          = 2'h0;
    hwrite          = 1'b0;
    hsize           = 3'h2;
    hwdata          = 32'h0000_0000;
    frame_n         = 1'b1;
    sec_mem_req     = 1'b0;
    sec_mem_addr    = 64'h0000_0000_0000_0000;
    down_window_hit = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values before any write.
    bus_read(8'h50, rd);
    chk(rd, 32'h0001_0001);
    // Table of ordinary writes and read-backs.
    foreach (rows[i]) begin
      bus_write(rows[i].addr, rows[i].wdata);
      bus_read(rows[i].addr, rd);
      chk(rd, rows[i].rexp);
    end
    // A reset in mid-run must restore every register.
    bus_write(8'h4C, 32'h3000_0000);
    bus_write(8'h50, 32'hABC0_DEF0);
    bus_write(8'h54, 32'hFFFF_FFFF);
    bus_write(8'h58, 32'hFFFF_FFFF);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus_read(8'h4C, rd);
    chk(rd, 32'h0000_0000);
    bus_read(8'h50, rd);
    chk(rd, 32'h0001_0001);
    bus_read(8'h54, rd);
    chk(rd, 32'h0000_0000);
    bus_read(8'h58, rd);
    chk(rd, 32'h0000_0000);
    bus_read(8'h48, rd);
    chk(rd, 32'h0000_0000);
    // Every delay code, then the two ends of the disabling codes.
    for (int c = 0; c < 8; c++) begin
      preempt_case(4'(c));
    end
    preempt_case(4'h8);
    preempt_case(4'hF);
    // Unconfined: upstream is everything outside the downstream window.
    win_case(64'h0000_0001_0010_0000, 1'b1, 1'b0);
    win_case(64'h0000_0001_0010_0000, 1'b0, 1'b1);
    // Confine to 0x1_0010_0000 .. 0x1_002F_FFFF and probe both edges.
    bus_write(8'h50, 32'h0020_0010);
    bus_write(8'h54, 32'h0000_0001);
    bus_write(8'h58, 32'h0000_0001);
    bus_write(8'h48, 32'h0001_0000);
    win_case(64'h0000_0001_0010_0000, 1'b0, 1'b1);
    win_case(64'h0000_0001_002F_FFFF, 1'b0, 1'b1);
    win_case(64'h0000_0001_000F_FFFF, 1'b0, 1'b0);
    win_case(64'h0000_0001_0030_0000, 1'b0, 1'b0);
    win_case(64'h0000_0000_0020_0000, 1'b0, 1'b0);
    test_done();
  end

  // Cuts a hang short and still reports through the closing task.
  initial begin
    #(WATCHDOG_NS);
    fails = fails + 1;
    test_done();
  end

endmodule
